/* dcpi_pkg.sv */
// package: constants and types for the dram command pin interface
package dcpi_pkg;
   localparam int ADDR_W = 16;
   localparam int BANK_W = 3;
   localparam int NUM_BANKS = 8;
   localparam int MR_NUM = 4;
   localparam int AP_BIT = 10;
   localparam int BC_BIT = 12;
   // mode register field positions (block-level configuration)
   localparam int MR0_OTF_BIT0 = 0;
   localparam int MR0_OTF_BIT1 = 1;
   localparam int MR1_RTT_LO = 2;
   localparam int MR1_RTT_MID = 6;
   localparam int MR1_RTT_HI = 9;
   localparam int MR1_TDQS_BIT = 11;
   localparam logic [15:0] MR_RESET = 16'h0000;
   localparam logic [1:0] BL_OTF = 2'h1;
   // command code {cs_n, ras_n, cas_n, we_n}
   typedef enum logic [3:0] {
      DCPI_CMD_MRS = 4'h0,
      DCPI_CMD_REF = 4'h1,
      DCPI_CMD_PRE = 4'h2,
      DCPI_CMD_ACT = 4'h3,
      DCPI_CMD_WR = 4'h4,
      DCPI_CMD_RD = 4'h5,
      DCPI_CMD_ZQ = 4'h6,
      DCPI_CMD_NOP = 4'h7
   } dcpi_cmd_type;
   // power states, gray along idle->pd->sr
   typedef enum logic [1:0] {
      DCPI_PW_ON = 2'h0,
      DCPI_PW_PPD = 2'h1,
      DCPI_PW_APD = 2'h3,
      DCPI_PW_SR = 2'h2
   } dcpi_pwr_type;
endpackage

/* dcpi_dec_if.sv */
// interface: decoded command from decoder to core
`timescale 1ns/1ns
interface dcpi_dec_if;
   logic valid;
   dcpi_pkg::dcpi_cmd_type cmd;
   modport dec (output valid, output cmd);
   modport core (input valid, input cmd);
endinterface

/* dcpi_cmd_decode.sv */
// module: registered command decoder gated by chip select
`timescale 1ns/1ns
module dcpi_cmd_decode (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic rx_en,
   input wire logic cs_n,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   dcpi_dec_if.dec dec
);
   logic valid_q;
   logic valid_d;
   dcpi_pkg::dcpi_cmd_type cmd_q;
   dcpi_pkg::dcpi_cmd_type cmd_d;

   always_comb begin
      valid_d = rx_en && !cs_n && !(ras_n && cas_n && we_n);
      cmd_d = dcpi_pkg::dcpi_cmd_type'({1'b0, ras_n, cas_n, we_n});
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         valid_q <= 1'b0;
         cmd_q <= dcpi_pkg::DCPI_CMD_NOP;
      end else begin
         valid_q <= valid_d;
         cmd_q <= cmd_d;
      end
   end

   assign dec.valid = valid_q;
   assign dec.cmd = cmd_q;

   a_cs_masks: assert property (@(posedge clk) disable iff (!rst_n)
      cs_n |=> !valid_q) else $error("command taken with chip select high");
   a_cmd_code: assert property (@(posedge clk) disable iff (!rst_n)
      valid_q |-> cmd_q == {1'b0, $past(ras_n), $past(cas_n), $past(we_n)})
      else $error("decoded command mismatch");
endmodule

/* dcpi_top.sv */
// module: dram command, address and control pin logic
// Summary of operation
// - activate takes row address; read/write take column and auto-precharge on a10.
// - precharge with a10 low closes one bank, high closes all banks.
// - load mode stores address inputs as the opcode.
// - with on-the-fly enabled, a12 high gives burst eight, low chop four.
// - bank inputs select the bank for activate, read, write, precharge.
// - during load mode bank inputs pick one of four mode registers.
// - all control and address inputs sampled on rising clock.
// - strobe output timed against the clock.
// - clock enable registered high enables circuitry, low disables it.
// - cke low idle gives precharge power-down or self refresh; open row active.
// - cke synchronous except for self refresh exit, which is asynchronous.
// - power-down keeps only clock, cke, reset, termination receivers; here wr_beat and data_mask still act in power-down.
// - self refresh keeps only cke and reset receivers.
// - commands decoded only while chip select registered low.
// - write beats with mask high are not written.
// - on x8 termination strobe mode disables write masking.
// - termination input high applies termination to data, strobe, mask.
// - termination disabled by mode register ignores termination pin.
// - command from row, column strobe, write enable, chip select together.
// - reset is active low and asynchronous.
`timescale 1ns/1ns
module dcpi_top #(
   parameter int ROW_W = 16,
   parameter int DQ_W = 8
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic cke,
   input wire logic cs_n,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   input wire logic [dcpi_pkg::BANK_W-1:0] bank_addr,
   input wire logic [dcpi_pkg::ADDR_W-1:0] addr,
   input wire logic odt,
   input wire logic data_mask,
   input wire logic wr_beat,
   output logic [dcpi_pkg::NUM_BANKS-1:0] bank_open,
   output logic [dcpi_pkg::ADDR_W-1:0] act_row,
   output logic [dcpi_pkg::ADDR_W-1:0] col_addr,
   output logic auto_pre,
   output logic burst_chop,
   output logic rd_go,
   output logic wr_go,
   output logic [dcpi_pkg::BANK_W-1:0] acc_bank,
   output logic [dcpi_pkg::ADDR_W-1:0] mr0,
   output logic [dcpi_pkg::ADDR_W-1:0] mr1,
   output logic [dcpi_pkg::ADDR_W-1:0] mr2,
   output logic [dcpi_pkg::ADDR_W-1:0] mr3,
   output logic [1:0] pwr_state,
   output logic clk_en_int,
   output logic [DQ_W-1:0] term_on,
   output logic strobe_term_on,
   output logic mask_term_on,
   output logic beat_write_en,
   output logic strobe_ref_clk
);
   if (ROW_W < 13 || ROW_W > dcpi_pkg::ADDR_W || (DQ_W != 8 && DQ_W != 4)) begin : g_bad_width
      $error("unsupported row or data width");
   end

   // ==========================================================
   // receiver enables and command decoder
   // ==========================================================
   dcpi_pkg::dcpi_pwr_type pwr_q;
   dcpi_pkg::dcpi_pwr_type pwr_d;
   logic cke_q;
   logic rx_cmd_en;
   dcpi_dec_if dec_bus ();

   // command counts only if cke was registered high on the edge before
   assign rx_cmd_en = cke_q && pwr_q == dcpi_pkg::DCPI_PW_ON;

   dcpi_cmd_decode u_dec (
      .clk(clk),
      .rst_n(reset_n),
      .rx_en(rx_cmd_en),
      .cs_n(cs_n),
      .ras_n(ras_n),
      .cas_n(cas_n),
      .we_n(we_n),
      .dec(dec_bus)
   );

   // address sampled on the same edge as the command
   logic [dcpi_pkg::ADDR_W-1:0] addr_q;
   logic [dcpi_pkg::BANK_W-1:0] ba_q;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         addr_q <= '0;
         ba_q <= '0;
      end else begin
         addr_q <= addr;
         ba_q <= bank_addr;
      end
   end

   function automatic logic is_cmd(input logic v, input dcpi_pkg::dcpi_cmd_type c,
                                   input dcpi_pkg::dcpi_cmd_type want);
      is_cmd = v && c == want;
   endfunction

   logic do_act;
   logic do_pre;
   logic do_rd;
   logic do_wr;
   logic do_mrs;
   logic do_ref;
   assign do_act = is_cmd(dec_bus.valid, dec_bus.cmd, dcpi_pkg::DCPI_CMD_ACT);
   assign do_pre = is_cmd(dec_bus.valid, dec_bus.cmd, dcpi_pkg::DCPI_CMD_PRE);
   assign do_rd = is_cmd(dec_bus.valid, dec_bus.cmd, dcpi_pkg::DCPI_CMD_RD);
   assign do_wr = is_cmd(dec_bus.valid, dec_bus.cmd, dcpi_pkg::DCPI_CMD_WR);
   assign do_mrs = is_cmd(dec_bus.valid, dec_bus.cmd, dcpi_pkg::DCPI_CMD_MRS);
   assign do_ref = is_cmd(dec_bus.valid, dec_bus.cmd, dcpi_pkg::DCPI_CMD_REF);

   // ==========================================================
   // banks, access and mode registers
   // ==========================================================
   logic [dcpi_pkg::NUM_BANKS-1:0] open_q;
   logic [dcpi_pkg::NUM_BANKS-1:0] open_d;
   logic [dcpi_pkg::ADDR_W-1:0] row_q;
   logic [dcpi_pkg::ADDR_W-1:0] row_d;
   logic [dcpi_pkg::ADDR_W-1:0] col_q;
   logic [dcpi_pkg::ADDR_W-1:0] col_d;
   logic ap_q;
   logic ap_d;
   logic bc_q;
   logic bc_d;
   logic rd_q;
   logic rd_d;
   logic wr_q;
   logic wr_d;
   logic [dcpi_pkg::BANK_W-1:0] bank_q;
   logic [dcpi_pkg::BANK_W-1:0] bank_d;
   logic [dcpi_pkg::ADDR_W-1:0] mr_q [dcpi_pkg::MR_NUM];
   logic [dcpi_pkg::ADDR_W-1:0] mr_d [dcpi_pkg::MR_NUM];
   logic [dcpi_pkg::ADDR_W-1:0] row_mask;
   logic otf_en;

   assign row_mask = dcpi_pkg::ADDR_W'((17'h1 << ROW_W) - 17'h1);
   assign otf_en = mr_q[0][dcpi_pkg::MR0_OTF_BIT1:dcpi_pkg::MR0_OTF_BIT0] == dcpi_pkg::BL_OTF;

   always_comb begin
      open_d = open_q;
      row_d = row_q;
      col_d = col_q;
      ap_d = ap_q;
      bc_d = bc_q;
      bank_d = bank_q;
      rd_d = do_rd;
      wr_d = do_wr;
      mr_d = mr_q;
      if (do_act) begin
         open_d[ba_q] = 1'b1;
         row_d = addr_q & row_mask;
         bank_d = ba_q;
      end
      if (do_pre) begin
         if (addr_q[dcpi_pkg::AP_BIT])
            open_d = '0;
         else
            open_d[ba_q] = 1'b0;
         bank_d = ba_q;
      end
      if (do_rd || do_wr) begin
         col_d = addr_q;
         ap_d = addr_q[dcpi_pkg::AP_BIT];
         bc_d = otf_en && !addr_q[dcpi_pkg::BC_BIT];
         bank_d = ba_q;
         if (addr_q[dcpi_pkg::AP_BIT])
            open_d[ba_q] = 1'b0;
      end
      if (do_mrs && ba_q[2] == 1'b0)
         mr_d[ba_q[1:0]] = addr_q;
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         open_q <= '0;
         row_q <= '0;
         col_q <= '0;
         ap_q <= 1'b0;
         bc_q <= 1'b0;
         rd_q <= 1'b0;
         wr_q <= 1'b0;
         bank_q <= '0;
         for (int i = 0; i < dcpi_pkg::MR_NUM; i++) begin
            mr_q[i] <= dcpi_pkg::MR_RESET;
         end
      end else begin
         open_q <= open_d;
         row_q <= row_d;
         col_q <= col_d;
         ap_q <= ap_d;
         bc_q <= bc_d;
         rd_q <= rd_d;
         wr_q <= wr_d;
         bank_q <= bank_d;
         mr_q <= mr_d;
      end
   end

   // ==========================================================
   // clock enable power states
   // ==========================================================
   always_comb begin
      pwr_d = pwr_q;
      case (pwr_q)
         dcpi_pkg::DCPI_PW_ON: begin
            if (!cke_q) begin
               if (do_ref)
                  pwr_d = dcpi_pkg::DCPI_PW_SR;
               else if (|open_q)
                  pwr_d = dcpi_pkg::DCPI_PW_APD;
               else
                  pwr_d = dcpi_pkg::DCPI_PW_PPD;
            end
         end
         dcpi_pkg::DCPI_PW_PPD, dcpi_pkg::DCPI_PW_APD: begin
            if (cke)
               pwr_d = dcpi_pkg::DCPI_PW_ON;
         end
         dcpi_pkg::DCPI_PW_SR: begin
            if (cke)
               pwr_d = dcpi_pkg::DCPI_PW_ON;
         end
         default: pwr_d = dcpi_pkg::DCPI_PW_ON;
      endcase
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n)
         cke_q <= 1'b0;
      else
         cke_q <= cke;
   end

   logic sr_q;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n)
         pwr_q <= dcpi_pkg::DCPI_PW_ON;
      else
         pwr_q <= pwr_d;
   end
   assign sr_q = pwr_q == dcpi_pkg::DCPI_PW_SR;

   // ==========================================================
   // termination and write mask
   // ==========================================================
   logic rtt_en;
   logic tdqs_en;
   logic odt_q;
   logic odt_d;
   assign rtt_en = mr_q[1][dcpi_pkg::MR1_RTT_LO] || mr_q[1][dcpi_pkg::MR1_RTT_MID]
                   || mr_q[1][dcpi_pkg::MR1_RTT_HI];
   assign tdqs_en = DQ_W == 8 && mr_q[1][dcpi_pkg::MR1_TDQS_BIT];

   always_comb begin
      odt_d = odt_q;
      if (sr_q || !rtt_en)
         odt_d = 1'b0;
      else
         odt_d = odt;
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n)
         odt_q <= 1'b0;
      else
         odt_q <= odt_d;
   end

   assign term_on = {DQ_W{odt_q}};
   assign strobe_term_on = odt_q;
   assign mask_term_on = odt_q;
   assign beat_write_en = wr_beat && !sr_q && (tdqs_en || !data_mask);

   // ==========================================================
   // outputs
   // ==========================================================
   assign bank_open = open_q;
   assign act_row = row_q;
   assign col_addr = col_q;
   assign auto_pre = ap_q;
   assign burst_chop = bc_q;
   assign rd_go = rd_q;
   assign wr_go = wr_q;
   assign acc_bank = bank_q;
   assign mr0 = mr_q[0];
   assign mr1 = mr_q[1];
   assign mr2 = mr_q[2];
   assign mr3 = mr_q[3];
   assign pwr_state = pwr_q;
   // self refresh exit follows cke without waiting for an edge
   assign clk_en_int = sr_q ? cke : cke_q;
   assign strobe_ref_clk = clk && pwr_q == dcpi_pkg::DCPI_PW_ON;

   // ==========================================================
   // checks
   // ==========================================================
   a_pre_all: assert property (@(posedge clk) disable iff (!reset_n)
      do_pre && addr_q[dcpi_pkg::AP_BIT] |=> open_q == '0)
      else $error("precharge all left a bank open");
   a_pre_one: assert property (@(posedge clk) disable iff (!reset_n)
      do_pre && !addr_q[dcpi_pkg::AP_BIT] |=> !open_q[$past(ba_q)])
      else $error("precharge bank still open");
   a_act_bank: assert property (@(posedge clk) disable iff (!reset_n)
      do_act |=> open_q[$past(ba_q)] && bank_q == $past(ba_q))
      else $error("activate did not open bank");
   a_mrs_load: assert property (@(posedge clk) disable iff (!reset_n)
      do_mrs && ba_q == 3'h2 |=> mr_q[2] == $past(addr_q))
      else $error("mode register not loaded");
   a_chop_sel: assert property (@(posedge clk) disable iff (!reset_n)
      (do_rd || do_wr) && otf_en |=> bc_q == !$past(addr_q[dcpi_pkg::BC_BIT]))
      else $error("burst chop wrong");
   a_apd_entry: assert property (@(posedge clk) disable iff (!reset_n)
      pwr_q == dcpi_pkg::DCPI_PW_ON && !cke_q && !do_ref && |open_q
      |=> pwr_q == dcpi_pkg::DCPI_PW_APD) else $error("active power-down missed");
   a_sr_entry: assert property (@(posedge clk) disable iff (!reset_n)
      pwr_q == dcpi_pkg::DCPI_PW_ON && !cke_q && do_ref |=> sr_q)
      else $error("self refresh entry missed");
   a_sr_exit: assert property (@(posedge clk) disable iff (!reset_n)
      sr_q && cke |-> clk_en_int ##1 pwr_q == dcpi_pkg::DCPI_PW_ON)
      else $error("self refresh exit missed");
   a_pd_nocmd: assert property (@(posedge clk) disable iff (!reset_n)
      pwr_q != dcpi_pkg::DCPI_PW_ON |=> !dec_bus.valid)
      else $error("command taken in power-down");
   a_odt_off: assert property (@(posedge clk) disable iff (!reset_n)
      !rtt_en |=> !odt_q) else $error("termination applied while disabled");
   a_mask_beat: assert property (@(posedge clk) disable iff (!reset_n)
      wr_beat && data_mask && !tdqs_en |-> !beat_write_en)
      else $error("masked beat written");
endmodule

/* dcpi_ctrl_model.sv */
// controller-side model that drives the command, address and clock enable pins
`timescale 1ns/1ns
module dcpi_ctrl_model (
   input wire logic clk,
   output logic cke,
   output logic cs_n,
   output logic ras_n,
   output logic cas_n,
   output logic we_n,
   output logic [dcpi_pkg::BANK_W-1:0] bank_addr,
   output logic [dcpi_pkg::ADDR_W-1:0] addr
);
   // ==========================================
   // pin drive
   initial begin
      cke = 1'b0;
      {cs_n, ras_n, cas_n, we_n} = 4'hF;
      bank_addr = 3'h0;
      addr = 16'h0000;
   end

   // one command per falling edge, held over the sampling rise
   task automatic issue(input dcpi_pkg::dcpi_cmd_type c, input logic [2:0] b,
      input logic [15:0] a, input logic k, input logic sel);
      @(negedge clk);
      {cs_n, ras_n, cas_n, we_n} = {~sel, c[2:0]};
      bank_addr = b;
      addr = a;
      cke = k;
   endtask

   // deselect: address lines no longer hold the last value
   task automatic idle(input int n);
      repeat (n) begin
         @(negedge clk);
         {cs_n, ras_n, cas_n, we_n} = 4'hF;
         bank_addr = ~bank_addr;
         addr = ~addr;
      end
   endtask
endmodule

/* dcpi_top_tb_top.sv */
// testbench for the dram command pin logic
`timescale 1ns/1ns
module dcpi_top_tb_top;
   localparam dcpi_pkg::dcpi_cmd_type C_ACT = dcpi_pkg::DCPI_CMD_ACT;
   localparam dcpi_pkg::dcpi_cmd_type C_PRE = dcpi_pkg::DCPI_CMD_PRE;
   localparam dcpi_pkg::dcpi_cmd_type C_NOP = dcpi_pkg::DCPI_CMD_NOP;
   localparam logic [15:0] RTT_V [4] = '{16'h0000, 16'h0004, 16'h0040, 16'h0200};
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic odt = 1'b0;
   logic data_mask = 1'b0;
   logic wr_beat = 1'b0;
   wire logic cke, cs_n, ras_n, cas_n, we_n;
   wire logic [2:0] bank_addr;
   wire logic [15:0] addr;
   logic [7:0] bank_open;
   logic [15:0] act_row, col_addr, mr0, mr1, mr2, mr3;
   logic auto_pre, burst_chop, rd_go, wr_go, clk_en_int;
   logic strobe_term_on, mask_term_on, beat_write_en, strobe_ref_clk;
   logic [2:0] acc_bank;
   logic [1:0] pwr_state;
   logic [7:0] term_on;
   logic [63:0] mr_all;
   int fail_count = 0;
   int n_checks = 0;
   logic [21:0] exp_q[$];
   logic [21:0] exp_w;
   logic [15:0] rnd, old;
   logic [7:0] open_e;
   logic [2:0] bk;
   logic otf;
   logic e;

   always #10 clk = ~clk;
   assign mr_all = {mr3, mr2, mr1, mr0};

   dcpi_ctrl_model ctrl_u (.clk(clk), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
      .cas_n(cas_n), .we_n(we_n), .bank_addr(bank_addr), .addr(addr));

   dcpi_top #(.ROW_W(16), .DQ_W(8)) dut_u (.clk(clk), .reset_n(reset_n), .cke(cke),
      .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .bank_addr(bank_addr),
      .addr(addr), .odt(odt), .data_mask(data_mask), .wr_beat(wr_beat),
      .bank_open(bank_open), .act_row(act_row), .col_addr(col_addr),
      .auto_pre(auto_pre), .burst_chop(burst_chop), .rd_go(rd_go), .wr_go(wr_go),
      .acc_bank(acc_bank), .mr0(mr0), .mr1(mr1), .mr2(mr2), .mr3(mr3),
      .pwr_state(pwr_state), .clk_en_int(clk_en_int), .term_on(term_on),
      .strobe_term_on(strobe_term_on), .mask_term_on(mask_term_on),
      .beat_write_en(beat_write_en), .strobe_ref_clk(strobe_ref_clk));

   // ==========================================
   // compare and report
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] t=%0t seen=%0h exp=%0h", $time, seen, exp);
      end
   endtask

   task automatic final_report();
      $display("checks=%0d errors=%0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // ==========================================
   // stimulus helpers
   task automatic mrs(input logic [2:0] b, input logic [15:0] v);
      ctrl_u.issue(dcpi_pkg::DCPI_CMD_MRS, b, v, 1'b1, 1'b1);
      ctrl_u.idle(2);
   endtask

   task automatic act(input logic [2:0] b, input logic [15:0] r);
      ctrl_u.issue(C_ACT, b, r, 1'b1, 1'b1);
      ctrl_u.idle(2);
      open_e[b] = 1'b1;
      check({bank_open, act_row, acc_bank}, {open_e, r, b});
   endtask

   task automatic rw(input logic wr, input logic [2:0] b, input logic [15:0] a);
      ctrl_u.issue(wr ? dcpi_pkg::DCPI_CMD_WR : dcpi_pkg::DCPI_CMD_RD, b, a, 1'b1, 1'b1);
      exp_q.push_back({wr, a, a[10], otf & ~a[12], b});
   endtask

   task automatic pwr(input logic k, input logic [1:0] st);
      ctrl_u.issue(C_NOP, 3'($urandom), 16'($urandom), k, 1'b1);
      ctrl_u.idle(3);
      check({pwr_state, clk_en_int}, {st, k});
   endtask

   // ==========================================
   // result watcher
   always @(negedge clk) begin
      if (rd_go === 1'b1 || wr_go === 1'b1) begin
         if (exp_q.size() == 0) begin
            check(64'h1, 64'h0);
         end else begin
            exp_w = exp_q.pop_front();
            check({rd_go, wr_go, col_addr, auto_pre, burst_chop, acc_bank},
               {~exp_w[21], exp_w});
         end
      end
   end

   initial begin
      #200000;
      fail_count++;
      final_report();
   end

   // ==========================================
   // main sequence
   initial begin
      void'($urandom(41572));
      open_e = 8'h00;
      otf = 1'b0;
      repeat (6) @(posedge clk);
      @(negedge clk);
      reset_n = 1'b1;
      check({bank_open, pwr_state}, 64'h0);
      check(mr_all, 64'h0);
      pwr(1'b1, dcpi_pkg::DCPI_PW_ON);
      for (int i = 0; i < 4; i++) begin
         rnd = 16'($urandom);
         mrs(i[2:0], rnd);
         check(mr_all[i*16 +: 16], rnd);
      end
      old = mr0;
      mrs({1'b1, 2'($urandom)}, ~old);
      check(mr0, old);
      for (int i = 0; i < 8; i++) begin
         mrs(3'h1, RTT_V[i/2]);
         odt = i[0];
         e = i[0] & (i > 1);
         ctrl_u.idle(2);
         check({term_on, strobe_term_on, mask_term_on}, {10{e}});
      end
      odt = 1'b0;
      for (int i = 0; i < 8; i++) begin
         if (i % 4 == 0) mrs(3'h1, i[2] ? 16'h0800 : 16'h0000);
         @(negedge clk);
         {wr_beat, data_mask} = i[1:0];
         #1;
         check(beat_write_en, wr_beat & (i[2] | ~data_mask));
      end
      {wr_beat, data_mask} = 2'h0;
      mrs(3'h1, 16'h0004);
      mrs(3'h0, 16'h0001);
      otf = 1'b1;
      bk = 3'($urandom);
      act(bk, 16'($urandom));
      act(bk ^ 3'h1, 16'($urandom));
      ctrl_u.issue(C_ACT, bk ^ 3'h2, 16'($urandom), 1'b1, 1'b0);
      ctrl_u.idle(2);
      check(bank_open, open_e);
      for (int i = 0; i < 4; i++) begin
         rw(i[0], bk, {3'h0, i[1], 2'h0, 10'(i * 8)});
      end
      rw(1'b0, bk, 16'h0400);
      ctrl_u.idle(3);
      open_e[bk] = 1'b0;
      check(bank_open, open_e);
      mrs(3'h0, 16'h0000);
      otf = 1'b0;
      rw(1'b1, bk ^ 3'h1, 16'($urandom) & 16'hFBFF);
      ctrl_u.idle(1);
      mrs(3'h0, 16'h0001);
      otf = 1'b1;
      act(bk, 16'($urandom));
      ctrl_u.issue(C_PRE, bk ^ 3'h1, 16'($urandom) & 16'hFBFF, 1'b1, 1'b1);
      ctrl_u.idle(2);
      open_e[bk ^ 3'h1] = 1'b0;
      check(bank_open, open_e);
      pwr(1'b0, dcpi_pkg::DCPI_PW_APD);
      ctrl_u.issue(C_PRE, 3'($urandom), 16'($urandom) | 16'h0400, 1'b0, 1'b1);
      ctrl_u.idle(2);
      check(bank_open, open_e);
      pwr(1'b1, dcpi_pkg::DCPI_PW_ON);
      ctrl_u.issue(C_PRE, 3'($urandom), 16'($urandom) | 16'h0400, 1'b1, 1'b1);
      ctrl_u.idle(2);
      open_e = 8'h00;
      check(bank_open, open_e);
      pwr(1'b0, dcpi_pkg::DCPI_PW_PPD);
      pwr(1'b1, dcpi_pkg::DCPI_PW_ON);
      ctrl_u.issue(dcpi_pkg::DCPI_CMD_REF, 3'($urandom), 16'($urandom), 1'b0, 1'b1);
      ctrl_u.idle(3);
      check({pwr_state, clk_en_int}, {dcpi_pkg::DCPI_PW_SR, 1'b0});
      wr_beat = 1'b1;
      #1;
      check(beat_write_en, 1'b0);
      wr_beat = 1'b0;
      ctrl_u.issue(C_NOP, 3'($urandom), 16'($urandom), 1'b1, 1'b1);
      #1;
      check({pwr_state, clk_en_int}, {dcpi_pkg::DCPI_PW_SR, 1'b1});
      pwr(1'b1, dcpi_pkg::DCPI_PW_ON);
      @(posedge clk);
      #5;
      check(strobe_ref_clk, 1'b1);
      @(negedge clk);
      #5;
      check(strobe_ref_clk, 1'b0);
      act(3'h5, 16'h00A5);
      @(negedge clk);
      reset_n = 1'b0;
      #3;
      check({bank_open, mr0}, 24'h0);
      repeat (2) @(negedge clk);
      reset_n = 1'b1;
      pwr(1'b1, dcpi_pkg::DCPI_PW_ON);
      for (int i = 0; i < 20 && exp_q.size() != 0; i++) @(negedge clk);
      check(exp_q.size(), 0);
      final_report();
   end
endmodule
